// ==== tb/board.sv ====
// board reset circuit and boot strap model
module board (
  // bench controls
  input wire logic press,
  input wire logic boot,
  // pins
  output logic reset_pin,
  output logic boot_select_strap
);
  timeunit 1ns;
  timeprecision 1ns;
  assign reset_pin = press;
  // strap pull-down fitted when boot is wanted
  assign boot_select_strap = !boot;
endmodule // board

// ==== tb/tb.sv ====
// testbench for the reset and boot-select sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, srst = 1, press = 0, boot = 0, wdt = 0, idl = 0, pd = 0;
  logic rp, bs, prst, crst, rb, ia, pa;
  int fails = 0, check_count = 0;
  board u_board (.press(press), .boot(boot), .reset_pin(rp), .boot_select_strap(bs));
  reset_and_boot_select dut (.mclk(mclk), .srst(srst), .reset_pin(rp),
    .boot_select_strap(bs), .supervisory_timer_expired(wdt), .idle_req(idl),
    .pdown_req(pd), .port_reset(prst), .chip_reset(crst), .run_bootloader(rb),
    .idle_active(ia), .pdown_active(pa));
  initial forever #10 mclk = ~mclk;
  task chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %b", $time, got);
    end
  endtask
  task hold(input int n);
    @(posedge mclk) press <= 1;
    repeat (n) @(posedge mclk);
    press <= 0;
  endtask
  task t_short;
    hold(40);
    hold(40);
    repeat (4) @(posedge mclk);
    #1 chk(crst, 0);
  endtask
  task t_port;
    @(posedge mclk) press <= 1;
    #1 chk(prst, 1);
    @(posedge mclk) press <= 0;
    #1 chk(prst, 1);
    repeat (2) @(posedge mclk);
    #1 chk(prst, 0);
    chk(crst, 0);
    repeat (3) @(posedge mclk);
    #1 chk(crst, 0);
  endtask
  task t_long(input logic b);
    @(posedge mclk) boot <= b;
    hold(70);
    #1 chk(crst, 1);
    chk(prst, 1);
    repeat (6) @(posedge mclk);
    #1 chk(crst, 0);
    chk(rb, b);
    chk(prst, 0);
  endtask
  task t_wdt;
    @(posedge mclk) wdt <= 1;
    @(posedge mclk) wdt <= 0;
    #1 chk(crst, 1);
    repeat (3) @(posedge mclk);
    #1 chk(crst, 0);
    chk(rb, 0);
  endtask
  task t_wake(input logic p);
    @(posedge mclk) {idl, pd} <= {!p, p};
    @(posedge mclk) {idl, pd} <= 2'h0;
    #1 chk(p ? pa : ia, 1);
    hold(3);
    repeat (2) @(posedge mclk);
    #1 chk(pa, 0);
    chk(ia, 0);
  endtask
  task end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 0;
    repeat (3) @(posedge mclk);
    t_short();
    t_port();
    t_long(1);
    t_long(0);
    t_wdt();
    t_wake(0);
    t_wake(1);
    end_sim();
  end
endmodule // tb

// ==== verilog/reset_and_boot_select.sv ====
// reset sequencer: qualifies reset input, merges supervisory timer reset, samples boot strap
module reset_and_boot_select
  import rst_boot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // board reset pin, active high
  input wire logic reset_pin,
  // boot select strap, low selects bootloader
  input wire logic boot_select_strap,
  // supervisory timer expiry pulse
  input wire logic supervisory_timer_expired,
  // low-power requests from the core
  input wire logic idle_req,
  input wire logic pdown_req,
  // outputs
  output logic port_reset,
  output logic chip_reset,
  output logic run_bootloader,
  output logic idle_active,
  output logic pdown_active
);
  import rst_boot_pkg::*;

  // synchronised pin level and its qualification
  logic pin_r;
  logic qualified;

  // registered outputs
  logic port_hold_r;
  logic chip_reset_r;
  logic boot_r;
  logic idle_r;
  logic pdown_r;

  // chip reset request ahead of its register
  logic chip_reset_nxt;

  // low-power state and its next value
  pwr_mode_t mode_r;
  pwr_mode_t mode_nxt;

  // consecutive high samples of the pin, read only by the checks
  logic [CNT_W-1:0] run_len_r;

  // pin level taken into the clock domain once
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= reset_pin;
    end
  end

  // qualification counter: 64 consecutive high samples before chip reset
  rst_qual u_qual (
    .mclk(mclk),
    .srst(srst),
    .level_in(pin_r),
    .qualified(qualified)
  );

  // port reset must act without the oscillator, so the pin itself drives it
  // the register only stretches it by one cycle and covers the block reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      port_hold_r <= 1'b1;
    end else begin
      port_hold_r <= reset_pin;
    end
  end

  assign port_reset = reset_pin || port_hold_r;

  // either source requests the whole chip to reset
  assign chip_reset_nxt = qualified || supervisory_timer_expired;

  always_ff @(posedge mclk) begin
    if (srst) begin
      chip_reset_r <= 1'b1;
    end else begin
      chip_reset_r <= chip_reset_nxt;
    end
  end

  // strap taken on the cycle chip reset releases
  always_ff @(posedge mclk) begin
    if (srst) begin
      boot_r <= 1'b0;
    end else if (chip_reset_r && !chip_reset_nxt) begin
      boot_r <= !boot_select_strap;
    end
  end

  // low-power state: any reset activity forces normal operation
  always_comb begin
    mode_nxt = mode_r;
    if (pin_r || chip_reset_r) begin
      mode_nxt = PWR_RUN;
    end else begin
      case (mode_r)
        PWR_RUN: begin
          if (pdown_req) begin
            mode_nxt = PWR_DOWN;
          end else if (idle_req) begin
            mode_nxt = PWR_IDLE;
          end
        end
        default: begin
          mode_nxt = mode_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_r <= PWR_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // mode flags registered from the next state so they leave on flip-flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= (mode_nxt == PWR_IDLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pdown_r <= 1'b0;
    end else begin
      pdown_r <= (mode_nxt == PWR_DOWN);
    end
  end

  // independent run-length count used by the checks
  always_ff @(posedge mclk) begin
    if (srst) begin
      run_len_r <= CNT_RST;
    end else if (!pin_r) begin
      run_len_r <= CNT_RST;
    end else if (run_len_r != QUAL_CNT) begin
      run_len_r <= run_len_r + 7'h01;
    end
  end

  assign chip_reset = chip_reset_r;
  assign run_bootloader = boot_r;
  assign idle_active = idle_r;
  assign pdown_active = pdown_r;

  // port reset acts in the same cycle as the pin
  port_follow_a: assert property (@(posedge mclk) disable iff (srst)
    reset_pin |-> port_reset) else $error("port reset not following pin");

  // port reset drops once the pin has been low for a cycle
  port_release_a: assert property (@(posedge mclk) disable iff (srst)
    !reset_pin && !$past(reset_pin) && !$past(srst) |-> !port_reset)
    else $error("port reset stuck after pin low");

  // a one-cycle pulse on an idle chip never resets it
  short_pulse_a: assert property (@(posedge mclk) disable iff (srst)
    !chip_reset && $rose(pin_r) ##1 !pin_r && !supervisory_timer_expired |=> !chip_reset)
    else $error("short reset pulse caused reset");

  // a completed run of high samples gives chip reset next cycle
  long_hold_a: assert property (@(posedge mclk) disable iff (srst)
    run_len_r == QUAL_CNT |=> chip_reset) else $error("held reset not honoured");

  // chip reset only rises after a full run or a timer expiry
  early_reset_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(chip_reset) |-> $past(supervisory_timer_expired) || $past(run_len_r) == QUAL_CNT)
    else $error("chip reset before qualification");

  // two low samples with no timer expiry release chip reset
  release_a: assert property (@(posedge mclk) disable iff (srst)
    !pin_r ##1 (!pin_r && !supervisory_timer_expired) |=> !chip_reset)
    else $error("chip reset held after pin low");

  // timer expiry always resets the chip
  wdt_reset_a: assert property (@(posedge mclk) disable iff (srst)
    supervisory_timer_expired |=> chip_reset) else $error("timer expiry missed");

  // pin activity leaves idle and power-down
  wake_run_a: assert property (@(posedge mclk) disable iff (srst)
    pin_r |=> !idle_active && !pdown_active) else $error("reset did not wake");

  // chip reset also holds normal operation
  reset_run_a: assert property (@(posedge mclk) disable iff (srst)
    chip_reset |=> !idle_active && !pdown_active)
    else $error("low power during chip reset");

  // power-down request is honoured from normal operation
  pdown_enter_a: assert property (@(posedge mclk) disable iff (srst)
    !pin_r && !chip_reset && !idle_active && !pdown_active && pdown_req |=> pdown_active)
    else $error("power-down request lost");

  // idle request is honoured from normal operation
  idle_enter_a: assert property (@(posedge mclk) disable iff (srst)
    !pin_r && !chip_reset && !idle_active && !pdown_active && idle_req && !pdown_req
    |=> idle_active) else $error("idle request lost");

  // the two low-power flags never stand together
  one_mode_a: assert property (@(posedge mclk) disable iff (srst)
    !(idle_active && pdown_active)) else $error("two low-power modes at once");

  // strap decision taken at release
  boot_sample_a: assert property (@(posedge mclk) disable iff (srst)
    $fell(chip_reset) |=> run_bootloader == !$past(boot_select_strap, 2))
    else $error("strap not sampled at release");

  // the boot decision changes only on a chip reset release
  boot_hold_a: assert property (@(posedge mclk) disable iff (srst)
    $changed(run_bootloader) |-> $past(chip_reset) && !chip_reset)
    else $error("boot decision changed outside release");
endmodule // reset_and_boot_select

// ==== verilog/rst_boot_pkg.sv ====
// constants and types for the reset and boot-select sequencer
package rst_boot_pkg;
  localparam int unsigned QUAL_PERIODS = 64;
  localparam int unsigned CNT_W = 7;
  localparam logic [CNT_W-1:0] QUAL_CNT = CNT_W'(QUAL_PERIODS);
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_IDLE,
    PWR_DOWN
  } pwr_mode_t;
endpackage

// ==== verilog/rst_qual.sv ====
// counter that qualifies the reset input over consecutive high samples
module rst_qual
  import rst_boot_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // sampled reset level
  input wire logic level_in,
  // qualified reset, high while input held long enough
  output logic qualified
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= CNT_RST;
    end else if (!level_in) begin
      cnt_r <= CNT_RST;
    end else if (cnt_r != QUAL_CNT) begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  assign qualified = (cnt_r == QUAL_CNT);
endmodule // rst_qual
